/* File: pkg/hts_pkg.sv */
// Constants and types shared by the sensor control block
package hts_pkg;
    // ------------------------------------------------------------------
    // Bus addresses and register pointers
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_NORMAL  = 7'h28;
    localparam logic [6:0] ADDR_ERROR   = 7'h4c;
    localparam logic [7:0] REG_STATUS   = 8'h09;
    localparam logic [7:0] REG_CTRL     = 8'h0c;
    localparam logic [7:0] CTRL_INIT    = 8'h00;
    // ------------------------------------------------------------------
    // Control fields and codes
    // ------------------------------------------------------------------
    localparam int         SS_LSB       = 0;
    localparam int         TS_LSB       = 3;
    localparam int         FLD_W        = 3;
    localparam logic [2:0] SS_SLEEP     = 3'h0;
    localparam logic [2:0] SS_MEAS      = 3'h1;
    localparam logic [2:0] SS_RESET     = 3'h4;
    localparam logic [2:0] TS_100       = 3'h2;
    localparam logic [2:0] TS_400       = 3'h3;
    localparam logic [2:0] TS_1000      = 3'h4;
    localparam logic [2:0] TS_ONESHOT   = 3'h7;
    // ------------------------------------------------------------------
    // Status state codes and counter limits
    // ------------------------------------------------------------------
    localparam logic [2:0] ST_SLEEP     = 3'h0;
    localparam logic [2:0] ST_MEAS      = 3'h1;
    localparam logic [2:0] ST_STBY      = 3'h5;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic [1:0] BOOT_SETTLE  = 2'h2;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ      = 250;
    localparam int T_STBY_A_MS  = 100;
    localparam int T_STBY_B_MS  = 400;
    localparam int T_STBY_C_MS  = 1000;
    localparam int T_CONV_US    = 1000;
    localparam int T_DONE_NS    = 1000;
    localparam int STBY_A_CYC   = T_STBY_A_MS * CLK_MHZ * 1000;
    localparam int STBY_B_CYC   = T_STBY_B_MS * CLK_MHZ * 1000;
    localparam int STBY_C_CYC   = T_STBY_C_MS * CLK_MHZ * 1000;
    localparam int CONV_CYC     = T_CONV_US * CLK_MHZ;
    localparam int DONE_CYC     = (T_DONE_NS * CLK_MHZ) / 1000;
    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        I_IDLE  = 7'h01, I_ADDR = 7'h02, I_AACK = 7'h04, I_WBYTE = 7'h08,
        I_WACK  = 7'h10, I_RBYTE = 7'h20, I_RACK = 7'h40
    } hts_i2c_t;
    typedef enum logic [3:0] {
        M_SLEEP = 4'h1, M_MEAS = 4'h2, M_STBY = 4'h4, M_ERR = 4'h8
    } hts_mode_t;
endpackage : hts_pkg

/* File: hdl/hts_sensor_ctrl.sv */
// Sensor control: bus target, operating modes, result and status registers
`timescale 1ns/10ps
module hts_sensor_ctrl #(
    parameter int RES_W     = 16,
    parameter int STBY_A    = hts_pkg::STBY_A_CYC,
    parameter int STBY_B    = hts_pkg::STBY_B_CYC,
    parameter int STBY_C    = hts_pkg::STBY_C_CYC,
    parameter int CONV      = hts_pkg::CONV_CYC,
    parameter int DONE_HOLD = hts_pkg::DONE_CYC
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe_n_out,
    input  wire logic             boot_fail_in,
    input  wire logic [RES_W-1:0] hum_result_in,
    input  wire logic [RES_W-1:0] temp_result_in,
    output logic                  conversion_done_out,
    output logic [7:0]            status_out
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] scl_sync_reg, sda_sync_reg;
    logic [1:0] boot_sync_reg;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_sync_reg  <= 3'h7;
            sda_sync_reg  <= 3'h7;
            boot_sync_reg <= 2'h0;
        end else begin
            scl_sync_reg  <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg  <= {sda_sync_reg[1:0], sda_in};
            boot_sync_reg <= {boot_sync_reg[0], boot_fail_in};
        end
    end
    logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
    assign scl_s    = scl_sync_reg[1];
    assign sda_s    = sda_sync_reg[1];
    assign scl_rise = scl_s & ~scl_sync_reg[2];
    assign scl_fall = ~scl_s & scl_sync_reg[2];
    assign start_c  = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
    assign stop_c   = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];
    // ------------------------------------------------------------------
    // Registers of both groups
    // ------------------------------------------------------------------
    hts_pkg::hts_i2c_t  i2c_st_reg, i2c_st_next;
    hts_pkg::hts_mode_t mode_reg, mode_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic [7:0]  shift_reg, shift_next, ptr_reg, ptr_next, ctrl_reg, ctrl_next;
    logic        drv_reg, drv_next, ph_reg, ph_next, mack_reg, mack_next;
    logic        rw_reg, rw_next, ptr_set_reg, ptr_set_next, first_reg, first_next;
    logic [1:0]  rd_idx_reg, rd_idx_next, boot_cnt_reg, boot_cnt_next;
    logic [31:0] tmr_reg, tmr_next, done_cnt_reg, done_cnt_next;
    logic        boot_load_error_flag_reg, boot_load_error_flag_next, err_info_reg, err_info_next;
    logic        rdy_reg, rdy_next, done_reg, done_next;
    logic [RES_W-1:0] hum_reg, hum_next, tmp_reg, tmp_next;
    logic [7:0]  rx_byte, tx_byte, status_w;
    logic [6:0]  my_addr;
    logic [2:0]  ss_w, ts_w, state_code;
    logic        ctrl_wr, res_rd, res_load, load_tx, ts_ok, meas_end;
    assign rx_byte = {shift_reg[6:0], sda_s};
    assign my_addr = boot_load_error_flag_reg ? hts_pkg::ADDR_ERROR : hts_pkg::ADDR_NORMAL;
    assign ss_w    = rx_byte[hts_pkg::SS_LSB +: hts_pkg::FLD_W];
    assign ts_w    = rx_byte[hts_pkg::TS_LSB +: hts_pkg::FLD_W];
    assign ts_ok   = ts_w inside {hts_pkg::TS_100, hts_pkg::TS_400, hts_pkg::TS_1000,
                                  hts_pkg::TS_ONESHOT};
    assign meas_end   = (mode_reg == hts_pkg::M_MEAS) && (tmr_reg == 32'h0000_0000);
    assign state_code = (mode_reg == hts_pkg::M_MEAS) ? hts_pkg::ST_MEAS :
                        (mode_reg == hts_pkg::M_STBY) ? hts_pkg::ST_STBY : hts_pkg::ST_SLEEP;
    assign status_w = {2'h0, boot_load_error_flag_reg, err_info_reg, rdy_reg, state_code};
    // ------------------------------------------------------------------
    // Transmit byte selection
    // ------------------------------------------------------------------
    always_comb begin
        res_load = 1'b0;
        if (ptr_set_reg && ptr_reg == hts_pkg::REG_STATUS) begin
            tx_byte = status_w;
        end else if (ptr_set_reg && ptr_reg == hts_pkg::REG_CTRL) begin
            tx_byte = ctrl_reg;
        end else begin
            res_load = 1'b1;
            unique case (rd_idx_reg)
                2'h0: tx_byte = hum_reg[RES_W-1 -: 8];
                2'h1: tx_byte = hum_reg[7:0];
                2'h2: tx_byte = tmp_reg[RES_W-1 -: 8];
                2'h3: tx_byte = tmp_reg[7:0];
            endcase
        end
    end
    // ------------------------------------------------------------------
    // Bus target engine
    // ------------------------------------------------------------------
    always_comb begin
        i2c_st_next = i2c_st_reg;  cnt_next = cnt_reg;  shift_next = shift_reg;
        drv_next = drv_reg;  ph_next = ph_reg;  mack_next = mack_reg;  rw_next = rw_reg;
        ptr_next = ptr_reg;  ptr_set_next = ptr_set_reg;  first_next = first_reg;
        rd_idx_next = rd_idx_reg;  ctrl_wr = 1'b0;  res_rd = 1'b0;  load_tx = 1'b0;
        if (start_c) begin
            i2c_st_next = hts_pkg::I_ADDR;
            cnt_next = 3'h0;  drv_next = 1'b0;  first_next = 1'b1;  rd_idx_next = 2'h0;
        end else if (stop_c) begin
            i2c_st_next = hts_pkg::I_IDLE;  drv_next = 1'b0;  ptr_set_next = 1'b0;
        end else begin
            unique case (i2c_st_reg)
                hts_pkg::I_IDLE: ;
                hts_pkg::I_ADDR: if (scl_rise) begin
                    shift_next = rx_byte;
                    cnt_next   = 3'(cnt_reg + 3'h1);
                    if (cnt_reg == hts_pkg::BIT_LAST) begin
                        if (rx_byte[7:1] == my_addr) begin
                            i2c_st_next = hts_pkg::I_AACK;  rw_next = rx_byte[0];  ph_next = 1'b0;
                        end else begin
                            i2c_st_next = hts_pkg::I_IDLE;
                        end
                    end
                end
                hts_pkg::I_AACK, hts_pkg::I_WACK: if (scl_fall) begin
                    if (!ph_reg) begin
                        drv_next = 1'b1;  ph_next = 1'b1;
                    end else begin
                        cnt_next = 3'h0;
                        if (rw_reg) begin
                            i2c_st_next = hts_pkg::I_RBYTE;  load_tx = 1'b1;
                        end else begin
                            i2c_st_next = hts_pkg::I_WBYTE;  drv_next = 1'b0;
                        end
                    end
                end
                hts_pkg::I_WBYTE: if (scl_rise) begin
                    shift_next = rx_byte;
                    cnt_next   = 3'(cnt_reg + 3'h1);
                    if (cnt_reg == hts_pkg::BIT_LAST) begin
                        i2c_st_next = hts_pkg::I_WACK;  ph_next = 1'b0;
                        if (first_reg) begin
                            ptr_next = rx_byte;  ptr_set_next = 1'b1;  first_next = 1'b0;
                        end else if (ptr_reg == hts_pkg::REG_CTRL) begin
                            ctrl_wr = 1'b1;
                        end
                    end
                end
                hts_pkg::I_RBYTE: if (scl_rise) begin
                    cnt_next = 3'(cnt_reg + 3'h1);
                    if (cnt_reg == hts_pkg::BIT_LAST) begin
                        i2c_st_next = hts_pkg::I_RACK;  ph_next = 1'b0;
                    end
                end else if (scl_fall) begin
                    shift_next = {shift_reg[6:0], 1'b0};  drv_next = ~shift_reg[6];
                end
                hts_pkg::I_RACK: if (scl_rise) begin
                    ph_next = 1'b1;  mack_next = sda_s;
                end else if (scl_fall) begin
                    if (!ph_reg) begin
                        drv_next = 1'b0;
                    end else if (!mack_reg) begin
                        i2c_st_next = hts_pkg::I_RBYTE;  cnt_next = 3'h0;  load_tx = 1'b1;
                    end else begin
                        i2c_st_next = hts_pkg::I_IDLE;
                    end
                end
            endcase
        end
        if (load_tx) begin
            shift_next = tx_byte;  drv_next = ~tx_byte[7];
            if (res_load) begin
                rd_idx_next = 2'(rd_idx_reg + 2'h1);
                res_rd      = (rd_idx_reg == 2'h0);
            end
        end
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            i2c_st_reg <= hts_pkg::I_IDLE;  cnt_reg <= 3'h0;  shift_reg <= 8'h00;
            drv_reg <= 1'b0;  ph_reg <= 1'b0;  mack_reg <= 1'b0;  rw_reg <= 1'b0;
            ptr_reg <= 8'h00;  ptr_set_reg <= 1'b0;  first_reg <= 1'b0;  rd_idx_reg <= 2'h0;
        end else begin
            i2c_st_reg <= i2c_st_next;  cnt_reg <= cnt_next;  shift_reg <= shift_next;
            drv_reg <= drv_next;  ph_reg <= ph_next;  mack_reg <= mack_next;  rw_reg <= rw_next;
            ptr_reg <= ptr_next;  ptr_set_reg <= ptr_set_next;  first_reg <= first_next;
            rd_idx_reg <= rd_idx_next;
        end
    end
    // ------------------------------------------------------------------
    // Operating mode, timers and flags
    // ------------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;  ctrl_next = ctrl_reg;  boot_load_error_flag_next = boot_load_error_flag_reg;
        err_info_next = err_info_reg;  hum_next = hum_reg;  tmp_next = tmp_reg;
        boot_cnt_next = boot_cnt_reg;  rdy_next = rdy_reg & ~res_rd;
        tmr_next = (tmr_reg == 32'h0000_0000) ? tmr_reg : 32'(tmr_reg - 32'h0000_0001);
        done_cnt_next = (done_cnt_reg == 32'h0000_0000) ? done_cnt_reg :
                        32'(done_cnt_reg - 32'h0000_0001);
        if (meas_end) begin
            hum_next = hum_result_in;  tmp_next = temp_result_in;
            rdy_next = 1'b1;  done_cnt_next = 32'(DONE_HOLD);
            if (ctrl_reg[hts_pkg::SS_LSB +: hts_pkg::FLD_W] == hts_pkg::SS_MEAS &&
                ctrl_reg[hts_pkg::TS_LSB +: hts_pkg::FLD_W] != hts_pkg::TS_ONESHOT) begin
                mode_next = hts_pkg::M_STBY;
                unique case (ctrl_reg[hts_pkg::TS_LSB +: hts_pkg::FLD_W])
                    hts_pkg::TS_100: tmr_next = 32'(STBY_A);
                    hts_pkg::TS_400: tmr_next = 32'(STBY_B);
                    default:         tmr_next = 32'(STBY_C);
                endcase
            end else begin
                mode_next = hts_pkg::M_SLEEP;
            end
        end else if (mode_reg == hts_pkg::M_STBY && tmr_reg == 32'h0000_0000) begin
            mode_next = hts_pkg::M_MEAS;  tmr_next = 32'(CONV);  rdy_next = 1'b0;
        end
        if (ctrl_wr) begin
            if (ss_w == hts_pkg::SS_RESET) begin
                ctrl_next = hts_pkg::CTRL_INIT;  boot_load_error_flag_next = 1'b0;  err_info_next = 1'b0;
                rdy_next = 1'b0;  mode_next = hts_pkg::M_SLEEP;
            end else if (mode_reg != hts_pkg::M_ERR) begin
                ctrl_next = rx_byte;
                if (ss_w == hts_pkg::SS_SLEEP) begin
                    err_info_next = 1'b0;
                    if (mode_reg == hts_pkg::M_STBY) mode_next = hts_pkg::M_SLEEP;
                end else if (ss_w == hts_pkg::SS_MEAS && ts_ok) begin
                    err_info_next = 1'b0;
                    if (mode_reg != hts_pkg::M_MEAS) begin
                        mode_next = hts_pkg::M_MEAS;  tmr_next = 32'(CONV);  rdy_next = 1'b0;
                    end
                end else begin
                    err_info_next = 1'b1;  mode_next = hts_pkg::M_SLEEP;
                end
            end
        end
        if (boot_cnt_reg == hts_pkg::BOOT_SETTLE) begin
            boot_cnt_next = 2'(boot_cnt_reg + 2'h1);
            if (boot_sync_reg[1]) begin
                boot_load_error_flag_next = 1'b1;  mode_next = hts_pkg::M_ERR;
            end
        end else if (boot_cnt_reg < hts_pkg::BOOT_SETTLE) begin
            boot_cnt_next = 2'(boot_cnt_reg + 2'h1);
        end
        done_next = (done_cnt_next != 32'h0000_0000);
    end
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg <= hts_pkg::M_SLEEP;  ctrl_reg <= hts_pkg::CTRL_INIT;  boot_load_error_flag_reg <= 1'b0;
            err_info_reg <= 1'b0;  rdy_reg <= 1'b0;  tmr_reg <= 32'h0000_0000;
            done_cnt_reg <= 32'h0000_0000;  done_reg <= 1'b0;  boot_cnt_reg <= 2'h0;
            hum_reg <= '0;  tmp_reg <= '0;
        end else begin
            mode_reg <= mode_next;  ctrl_reg <= ctrl_next;  boot_load_error_flag_reg <= boot_load_error_flag_next;
            err_info_reg <= err_info_next;  rdy_reg <= rdy_next;  tmr_reg <= tmr_next;
            done_cnt_reg <= done_cnt_next;  done_reg <= done_next;
            boot_cnt_reg <= boot_cnt_next;  hum_reg <= hum_next;  tmp_reg <= tmp_next;
        end
    end
    assign sda_out             = 1'b0;
    assign sda_oe_n_out        = ~drv_reg;
    assign conversion_done_out = done_reg;
    assign status_out          = status_w;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic addr_done;
    assign addr_done = i2c_st_reg == hts_pkg::I_ADDR && scl_rise && !start_c && !stop_c &&
                       cnt_reg == hts_pkg::BIT_LAST;
    addr_ack_a: assert property (addr_done && !boot_load_error_flag_reg && rx_byte[7:1] == hts_pkg::ADDR_NORMAL
        |=> i2c_st_reg == hts_pkg::I_AACK) else $error("normal address not taken");
    lockout_a: assert property (addr_done && boot_load_error_flag_reg && rx_byte[7:1] == hts_pkg::ADDR_NORMAL
        |=> i2c_st_reg == hts_pkg::I_IDLE) else $error("locked device answered");
    err_addr_a: assert property (addr_done && boot_load_error_flag_reg && rx_byte[7:1] == hts_pkg::ADDR_ERROR
        |=> i2c_st_reg == hts_pkg::I_AACK) else $error("error address not taken");
    ctrl_write_a: assert property (ctrl_wr && !boot_load_error_flag_reg && ss_w != hts_pkg::SS_RESET
        |=> ctrl_reg == $past(rx_byte)) else $error("control write lost");
    meas_start_a: assert property (ctrl_wr && !boot_load_error_flag_reg && ss_w == hts_pkg::SS_MEAS && ts_ok &&
        mode_reg == hts_pkg::M_SLEEP |=> mode_reg == hts_pkg::M_MEAS && !rdy_reg)
        else $error("measurement not started");
    one_shot_a: assert property (meas_end && !ctrl_wr &&
        ctrl_reg[hts_pkg::TS_LSB +: hts_pkg::FLD_W] == hts_pkg::TS_ONESHOT
        |=> mode_reg == hts_pkg::M_SLEEP) else $error("single shot did not sleep");
    repeat_a: assert property (mode_reg == hts_pkg::M_STBY && tmr_reg == 32'h0000_0000 && !ctrl_wr
        |=> mode_reg == hts_pkg::M_MEAS) else $error("repeat did not restart");
    done_a: assert property (meas_end |=> conversion_done_out && rdy_reg && hum_reg == $past(hum_result_in))
        else $error("done or result missing");
    rdy_clr_a: assert property (res_rd && !meas_end && !(mode_reg == hts_pkg::M_STBY)
        |=> !rdy_reg) else $error("result read kept ready");
    status_a: assert property (load_tx && ptr_set_reg && ptr_reg == hts_pkg::REG_STATUS
        |=> shift_reg == $past(status_w)) else $error("status not sent");
    oneshot_c: cover property (meas_end ##1 mode_reg == hts_pkg::M_SLEEP);
    repeat_c: cover property (mode_reg == hts_pkg::M_STBY ##1 mode_reg == hts_pkg::M_MEAS);
    err_c: cover property (boot_load_error_flag_reg && i2c_st_reg == hts_pkg::I_AACK);
    status_c: cover property (load_tx && ptr_reg == hts_pkg::REG_STATUS && ptr_set_reg);
endmodule : hts_sensor_ctrl

/* File: sim/hts_host.sv */
// Bus controller model on the far side of the sensor's serial pins
`timescale 1ns/10ps
module hts_host (
    input  wire logic core_clk_in,
    input  wire logic sda_in,
    output logic      scl_out      = 1'b1,
    output logic      sda_oe_n_out = 1'b1
);
    task automatic drive(input logic c, input logic d, input int n);
        scl_out = c;
        sda_oe_n_out = d;
        repeat (n) @(negedge core_clk_in);
    endtask : drive
    task automatic seq(input logic [7:0] p); // Start 78h, stop 2Fh
        for (int i = 3; i >= 0; i--) begin
            drive(p[2 * i + 1], p[2 * i], 10);
        end
    endtask : seq
    task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            drive(1'b0, d[i], 10);
            drive(1'b1, d[i], 8);
            q[i] = sda_in;
            drive(1'b0, d[i], 2);
        end
    endtask : xbyte
endmodule : hts_host

/* File: sim/hts_sensor_ctrl_bench.sv */
// Self-checking bench for the sensor control block and its host model
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module hts_sensor_ctrl_bench;
    localparam logic [6:0]  ADR   = hts_pkg::ADDR_NORMAL;
    localparam logic [7:0]  START = 8'h78, STOP = 8'h2f;
    localparam logic [7:0]  STS   = hts_pkg::REG_STATUS, CTL = hts_pkg::REG_CTRL;
    localparam logic [31:0] RES   = 32'h1234_5678;
    localparam int          BOOT_WAIT = 20; // Scaled-down power-up wait
    logic       core_clk_in = 1'b0, rst_n_in = 1'b0, boot_fail_in = 1'b0;
    logic       scl, host_oe_n, dev_oe_n, dev_sda, done;
    logic [7:0] sts;
    logic [8:0] q;
    logic [31:0] res = RES;
    int         err_count = 0, n_checks = 0, cnt = 0, per;
    wire logic  sda = host_oe_n & (dev_oe_n | dev_sda); // Pull-up unless a party pulls low
    always #2 core_clk_in = ~core_clk_in;
    always @(posedge done) cnt++;
    hts_sensor_ctrl #(.STBY_A(200), .STBY_B(300), .STBY_C(400), .CONV(100), .DONE_HOLD(4))
        u_hts_sensor_ctrl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
        .sda_in(sda), .sda_out(dev_sda), .sda_oe_n_out(dev_oe_n), .boot_fail_in(boot_fail_in),
        .hum_result_in(res[31:16]), .temp_result_in(res[15:0]), .conversion_done_out(done),
        .status_out(sts));
    hts_host u_hts_host (.core_clk_in(core_clk_in), .sda_in(sda), .scl_out(scl),
        .sda_oe_n_out(host_oe_n));
    task automatic tx(input logic [7:0] b, input logic ack_exp);
        u_hts_host.xbyte({b, 1'b1}, q);
        `CHK(q[0], ~ack_exp)
    endtask : tx
    task automatic rd_res(input logic [31:0] e);
        u_hts_host.seq(START);
        tx({ADR, 1'b1}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_hts_host.xbyte({8'hff, i == 3}, q);
            `CHK(q[8:1], e[31 - 8 * i -: 8])
        end
        u_hts_host.seq(STOP);
    endtask : rd_res
    task automatic acc(input logic [6:0] a, input logic [7:0] p, v, input logic rd);
        u_hts_host.seq(START);
        tx({a, 1'b0}, 1'b1);
        tx(p, 1'b1);
        if (!rd) tx(v, 1'b1);
        if (rd) begin
            u_hts_host.seq(START);
            tx({a, 1'b1}, 1'b1);
            u_hts_host.xbyte(9'h1ff, q);
            `CHK(q[8:1], v)
            if (p == STS) `CHK(sts, v)
        end
        u_hts_host.seq(STOP);
    endtask : acc
    task automatic count_done(input int n);
        cnt = 0;
        repeat (n) @(negedge core_clk_in);
    endtask : count_done
    task automatic do_reset(input logic bf);
        boot_fail_in = bf;
        rst_n_in = 1'b0;
        repeat (6) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (BOOT_WAIT) @(negedge core_clk_in); // Bus idle after release
    endtask : do_reset
    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge core_clk_in);
        err_count++;
        final_report();
    end
    initial begin
        do_reset(1'b0);
        acc(ADR, STS, 8'h00, 1'b1);
        acc(ADR, CTL, {2'h0, hts_pkg::TS_ONESHOT, hts_pkg::SS_MEAS}, 1'b0);
        count_done(300);
        `CHK(cnt, 1)
        acc(ADR, STS, 8'h08, 1'b1);
        rd_res(RES);
        acc(ADR, STS, 8'h00, 1'b1);
        res = ~RES;
        for (int t = hts_pkg::TS_100; t <= hts_pkg::TS_1000; t++) begin
            per = 100 * t + 100;
            acc(ADR, CTL, {2'h0, t[2:0], hts_pkg::SS_MEAS}, 1'b0);
            count_done(1300);
            `CHK(cnt inside {[1300 / per : 1300 / per + 1]}, 1'b1)
            acc(ADR, CTL, 8'h00, 1'b0);
            count_done(300);
        end
        acc(ADR, STS, 8'h08, 1'b1);
        rd_res(~RES);
        // Prohibited operation code: stored, flagged, device sleeps
        acc(ADR, CTL, 8'h12, 1'b0);
        acc(ADR, CTL, 8'h12, 1'b1);
        acc(ADR, STS, 8'h10, 1'b1);
        do_reset(1'b1);
        u_hts_host.seq(START);
        tx({ADR, 1'b0}, 1'b0);
        u_hts_host.seq(STOP);
        acc(hts_pkg::ADDR_ERROR, STS, 8'h20, 1'b1);
        acc(hts_pkg::ADDR_ERROR, CTL, {5'h00, hts_pkg::SS_RESET}, 1'b0);
        acc(ADR, STS, 8'h00, 1'b1);
        final_report();
    end
endmodule : hts_sensor_ctrl_bench
